//--- verilog/diuch_pkg.sv
// Constants and types for the dual image update command handler
package diuch_pkg;

    // ------------------------------------------------------------
    // Packet framing
    // ------------------------------------------------------------
    localparam int CMD_LEN       = 69;
    localparam int RSP_LEN       = 5;
    localparam int CHUNK_BYTES   = 64;
    localparam int IDX_CMD       = 2;
    localparam int IDX_DATA0     = 3;
    localparam int IDX_LAST_DATA = 66;

    // ------------------------------------------------------------
    // Command and response codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_DATA     = 8'h01;
    localparam logic [7:0] CMD_VERSION  = 8'h02;
    localparam logic [7:0] CMD_RESET    = 8'h03;
    localparam logic [7:0] CMD_DONE     = 8'h04;
    localparam logic [7:0] CMD_SWAP     = 8'h05;
    localparam logic [7:0] CMD_START    = 8'h06;
    localparam logic [7:0] CMD_GET_SWAP = 8'h07;
    localparam logic [7:0] CMD_GET_APP  = 8'h08;

    localparam logic [7:0] RSP_READY    = 8'h01;
    localparam logic [7:0] RSP_ACK_PKT  = 8'h02;
    localparam logic [7:0] RSP_NAK_PKT  = 8'h03;
    localparam logic [7:0] RSP_VERSION  = 8'h04;
    localparam logic [7:0] RSP_ACK_PROG = 8'h05;
    localparam logic [7:0] RSP_NAK_PROG = 8'h06;
    localparam logic [7:0] RSP_NAK_CRC  = 8'h07;
    localparam logic [7:0] RSP_SWAP     = 8'h08;
    localparam logic [7:0] RSP_APP      = 8'h09;

    localparam logic [15:0] FILL16 = 16'hAAAA;

    // ------------------------------------------------------------
    // CRC and flash addressing
    // ------------------------------------------------------------
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [15:0] CRC_SEED = 16'h0000;
    localparam logic [15:0] CRC_OK   = 16'h0000;

    localparam logic [23:0] PTR_START     = 24'h00_1000;
    localparam logic [23:0] PTR_BOOT_END  = 24'h00_2000;
    localparam logic [23:0] ALT_LOWER     = 24'h00_2000;
    localparam logic [23:0] ALT_UPPER     = 24'h04_1000;
    localparam logic [23:0] PTR_STEP      = 24'h00_0040;

    typedef enum logic [3:0] {
        DIUCH_IDLE   = 4'b0000,
        DIUCH_RECV   = 4'b0001,
        DIUCH_CHECK  = 4'b0010,
        DIUCH_DISP   = 4'b0011,
        DIUCH_WRITE  = 4'b0100,
        DIUCH_ERASE  = 4'b0101,
        DIUCH_VERIFY = 4'b0110,
        DIUCH_SEND   = 4'b0111,
        DIUCH_RESET  = 4'b1000
    } diuch_state_e;

endpackage

//--- verilog/diuch_crc16.sv
// Byte-wide reflected CRC-CCITT update step
`timescale 1ns/100ps
module diuch_crc16 (
    // Current value and byte
    input  wire logic [15:0] crc_in,
    input  wire logic [7:0]  data,
    // Updated value
    output logic      [15:0] crc_out
);
    import diuch_pkg::*;

    logic [15:0] stage [0:8];

    assign stage[0] = crc_in ^ {8'h00, data};

    // One shift per bit, low bit first
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_bit
            assign stage[g+1] = stage[g][0] ?
                ((stage[g] >> 1) ^ CRC_POLY) : (stage[g] >> 1);
        end
    endgenerate

    assign crc_out = stage[8];

endmodule

//--- verilog/diuch_top.sv
// Command interpreter for dual image firmware update
`timescale 1ns/100ps
module diuch_top #(
    parameter logic [31:0] APP_REVISION = 32'h0000_0001,
    parameter logic [31:0] APP_ID       = 32'h4150_5030
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // Received byte stream
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    // Transmit byte stream
    output logic             tx_valid,
    output logic [7:0]       tx_data,
    input  wire logic        tx_ready,
    // Flash programming port
    output logic             fl_write,
    output logic             fl_erase,
    output logic [23:0]      fl_addr,
    output logic [7:0]       fl_wdata,
    input  wire logic        fl_done,
    input  wire logic        fl_error,
    // Image state
    input  wire logic        upper_alt,
    input  wire logic [15:0] image_crc_ref,
    // System controls
    output logic             boot_swap,
    output logic             sys_reset
);
    import diuch_pkg::*;

    diuch_state_e   state;
    diuch_state_e   next_state;
    logic [7:0]     pkt [0:CMD_LEN-1];
    logic [6:0]     rx_cnt;
    logic [15:0]    pkt_crc;
    logic [15:0]    img_crc;
    logic [15:0]    pkt_count;
    logic [23:0]    wptr;
    logic [6:0]     wcnt;
    logic [2:0]     tx_cnt;
    logic [7:0]     rsp [0:RSP_LEN-1];
    logic           fl_busy;

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    wire [15:0] pkt_crc_next;
    wire [15:0] img_crc_next;
    wire [7:0]  cmd       = pkt[IDX_CMD];
    wire [15:0] count_in  = {pkt[0], pkt[1]};
    wire        crc_good  = (pkt_crc == CRC_OK);
    wire        last_rx   = rx_valid && (rx_cnt == 7'(CMD_LEN - 1));
    wire [23:0] ptr_inc   = wptr + PTR_STEP;
    wire [23:0] alt_start = upper_alt ? ALT_UPPER : ALT_LOWER;
    wire [23:0] ptr_adv   = (ptr_inc == PTR_BOOT_END) ?
                            alt_start : ptr_inc;
    wire        wr_last   = (wcnt == 7'(CHUNK_BYTES - 1));
    wire        tx_last   = tx_ready && (tx_cnt == 3'(RSP_LEN - 1));
    wire        known_cmd = (cmd >= CMD_DATA) && (cmd <= CMD_GET_APP);

    diuch_crc16 u_pkt_crc (
        .crc_in  (pkt_crc),
        .data    (rx_data),
        .crc_out (pkt_crc_next)
    );

    diuch_crc16 u_img_crc (
        .crc_in  (img_crc),
        .data    (fl_wdata),
        .crc_out (img_crc_next)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            DIUCH_IDLE:   if (rx_valid) next_state = DIUCH_RECV;
            DIUCH_RECV:   if (last_rx) next_state = DIUCH_CHECK;
            DIUCH_CHECK:  next_state = crc_good ? DIUCH_DISP : DIUCH_SEND;
            DIUCH_DISP: begin
                unique case (cmd)
                    CMD_DATA:  next_state = DIUCH_WRITE;
                    CMD_START: next_state = DIUCH_ERASE;
                    CMD_DONE:  next_state = DIUCH_VERIFY;
                    default:   next_state = DIUCH_SEND;
                endcase
            end
            DIUCH_WRITE: begin
                if (fl_busy && fl_error) begin
                    next_state = DIUCH_SEND;
                end else if (fl_busy && fl_done && wr_last) begin
                    next_state = DIUCH_SEND;
                end
            end
            DIUCH_ERASE:  if (fl_busy && (fl_done || fl_error))
                              next_state = DIUCH_SEND;
            DIUCH_VERIFY: next_state = DIUCH_SEND;
            DIUCH_SEND: begin
                if (tx_last) begin
                    next_state = ((cmd == CMD_RESET || cmd == CMD_SWAP)
                                  && crc_good) ? DIUCH_RESET : DIUCH_IDLE;
                end
            end
            DIUCH_RESET:  next_state = DIUCH_IDLE;
            default:      next_state = DIUCH_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= DIUCH_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Packet capture and packet CRC
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_cnt  <= 7'd0;
            pkt_crc <= CRC_SEED;
        end else if ((state == DIUCH_IDLE || state == DIUCH_RECV)
                     && rx_valid) begin
            rx_cnt  <= last_rx ? 7'd0 : rx_cnt + 7'd1;
            pkt_crc <= pkt_crc_next;
        end else if (state == DIUCH_SEND && tx_last) begin
            pkt_crc <= CRC_SEED;
        end
    end

    always_ff @(posedge clk) begin
        if ((state == DIUCH_IDLE || state == DIUCH_RECV) && rx_valid) begin
            pkt[rx_cnt] <= rx_data;
        end
    end

    // ------------------------------------------------------------
    // Flash sequencing, write pointer and image CRC
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fl_write  <= 1'b0;
            fl_erase  <= 1'b0;
            fl_addr   <= 24'h00_0000;
            fl_wdata  <= 8'h00;
            fl_busy   <= 1'b0;
            wcnt      <= 7'd0;
            wptr      <= PTR_START;
            img_crc   <= CRC_SEED;
            pkt_count <= 16'h0000;
        end else begin
            fl_write <= 1'b0;
            fl_erase <= 1'b0;
            if (state == DIUCH_DISP) begin
                pkt_count <= count_in;
                wcnt      <= 7'd0;
                if (cmd == CMD_START) begin
                    fl_erase <= 1'b1;
                    fl_busy  <= 1'b1;
                    wptr     <= PTR_START;
                    img_crc  <= CRC_SEED;
                end else if (cmd == CMD_DATA) begin
                    fl_write <= 1'b1;
                    fl_busy  <= 1'b1;
                    fl_addr  <= wptr;
                    fl_wdata <= pkt[IDX_DATA0];
                end
            end else if (state == DIUCH_WRITE && fl_busy) begin
                if (fl_error) begin
                    fl_busy <= 1'b0;
                end else if (fl_done) begin
                    img_crc <= img_crc_next;
                    if (wr_last) begin
                        fl_busy <= 1'b0;
                        wptr    <= ptr_adv;
                    end else begin
                        wcnt     <= wcnt + 7'd1;
                        fl_write <= 1'b1;
                        fl_addr  <= fl_addr + 24'h00_0001;
                        fl_wdata <= pkt[7'(IDX_DATA0) + wcnt + 7'd1];
                    end
                end
            end else if (state == DIUCH_ERASE && fl_busy &&
                         (fl_done || fl_error)) begin
                fl_busy <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Response build and transmit
    // ------------------------------------------------------------
    logic [7:0]  next_type;
    logic [15:0] next_a;
    logic [15:0] next_b;
    logic        wr_fail;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_fail <= 1'b0;
        end else if (state == DIUCH_DISP) begin
            wr_fail <= 1'b0;
        end else if ((state == DIUCH_WRITE || state == DIUCH_ERASE)
                     && fl_busy && fl_error) begin
            wr_fail <= 1'b1;
        end
    end

    always_comb begin
        next_type = RSP_NAK_PKT;
        next_a    = pkt_count;
        next_b    = FILL16;
        if (!crc_good) begin
            next_type = RSP_NAK_CRC;
            next_a    = count_in;
        end else if (!known_cmd) begin
            next_type = RSP_NAK_PKT;
            next_a    = count_in;
        end else begin
            unique case (cmd)
                CMD_DATA: begin
                    next_type = (wr_fail || fl_error) ?
                                RSP_NAK_PKT : RSP_ACK_PKT;
                    next_b    = (wr_fail || fl_error) ? FILL16 : img_crc_next;
                end
                CMD_VERSION: begin
                    next_type = RSP_VERSION;
                    next_a    = APP_REVISION[31:16];
                    next_b    = APP_REVISION[15:0];
                end
                CMD_DONE: begin
                    next_type = (img_crc == image_crc_ref) ?
                                RSP_ACK_PROG : RSP_NAK_PROG;
                    next_b    = img_crc;
                end
                CMD_START: begin
                    next_type = RSP_READY;
                    next_a    = FILL16;
                end
                CMD_GET_SWAP: begin
                    next_type = RSP_SWAP;
                    next_a    = {15'h0000, boot_swap};
                end
                CMD_GET_APP: begin
                    next_type = RSP_APP;
                    next_a    = APP_ID[31:16];
                    next_b    = APP_ID[15:0];
                end
                default: begin
                    next_type = RSP_NAK_PKT;
                end
            endcase
        end
    end

    wire rsp_load = (next_state == DIUCH_SEND) && (state != DIUCH_SEND);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_valid <= 1'b0;
            tx_data  <= 8'h00;
            tx_cnt   <= 3'd0;
            rsp[0] <= 8'h00;
            rsp[1] <= 8'h00;
            rsp[2] <= 8'h00;
            rsp[3] <= 8'h00;
            rsp[4] <= 8'h00;
        end else if (rsp_load) begin
            rsp[0]   <= next_type;
            rsp[1]   <= next_a[15:8];
            rsp[2]   <= next_a[7:0];
            rsp[3]   <= next_b[15:8];
            rsp[4]   <= next_b[7:0];
            tx_valid <= 1'b1;
            tx_data  <= next_type;
            tx_cnt   <= 3'd0;
        end else if (tx_valid && tx_ready) begin
            if (tx_last) begin
                tx_valid <= 1'b0;
            end else begin
                tx_cnt  <= tx_cnt + 3'd1;
                tx_data <= rsp[tx_cnt + 3'd1];
            end
        end
    end

    // ------------------------------------------------------------
    // Reset and boot swap control
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            boot_swap <= 1'b0;
            sys_reset <= 1'b0;
        end else begin
            sys_reset <= (next_state == DIUCH_RESET);
            if (next_state == DIUCH_RESET && cmd == CMD_SWAP) begin
                boot_swap <= ~boot_swap;
            end
        end
    end

endmodule

//--- tb/diuch_checker.sv
// Port-level assertions for the update command handler
`timescale 1ns/100ps
module diuch_checker (
    // Watched ports
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        tx_valid,
    input wire logic [7:0]  tx_data,
    input wire logic        tx_ready,
    input wire logic        fl_write,
    input wire logic        fl_erase,
    input wire logic [23:0] fl_addr,
    input wire logic        upper_alt,
    input wire logic        boot_swap,
    input wire logic        sys_reset
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [23:0] last_addr;
    logic [2:0]  rsp_pos;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            last_addr <= 24'h00_0000;
            rsp_pos   <= 3'h0;
        end else begin
            if (fl_write)
                last_addr <= fl_addr;
            if (tx_valid && tx_ready)
                rsp_pos <= (rsp_pos == 3'h4) ? 3'h0 : rsp_pos + 3'h1;
        end
    end
    sequence s_write_gap;
        !fl_write [*2];
    endsequence
    sequence s_erase_wait;
        !tx_valid [*2];
    endsequence
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_tx_hold_byte: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("response byte changed before acceptance");
    a_rsp_type_code: assert property (
        tx_valid && rsp_pos == 3'h0 |-> tx_data inside {[8'h01:8'h09]})
        else $error("first response byte is not a type code");
    a_write_gap: assert property (fl_write |=> s_write_gap)
        else $error("flash write issued before completion");
    a_write_region: assert property (
        fl_write |-> fl_addr[23:12] == 12'h001 || (upper_alt ?
        fl_addr >= 24'h04_1000 :
        (fl_addr >= 24'h00_2000 && fl_addr < 24'h04_1000)))
        else $error("flash write outside target regions");
    a_write_step: assert property (
        fl_write && fl_addr[5:0] != 6'h00 |-> fl_addr == last_addr + 24'h1)
        else $error("flash byte address not consecutive");
    a_busy_no_tx: assert property (fl_write || fl_erase |-> !tx_valid)
        else $error("response sent while flash busy");
    a_erase_wait: assert property (fl_erase |=> s_erase_wait)
        else $error("ready answer before erase finished");
    a_reset_pulse: assert property (sys_reset |=> !sys_reset)
        else $error("system reset longer than one cycle");
    a_swap_hold: assert property (fl_write |-> $stable(boot_swap))
        else $error("boot swap changed during programming");
endmodule

//--- tb/diuch_host_model.sv
// Host update program model: sends command packets, takes responses
`timescale 1ns/100ps
module diuch_host_model (
    // Clock
    input  wire logic       clk,
    // Command bytes
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    // Response bytes
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready
);
    logic slow = 1'b0;
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        tx_ready = 1'b0;
    end
    // Whole packet, idle data inverted between bytes
    task automatic send_pkt(input logic [7:0] pkt [69]);
        for (int i = 0; i < 69; i++) begin
            @(negedge clk);
            rx_valid = 1'b1;
            rx_data  = pkt[i];
            @(negedge clk);
            rx_valid = 1'b0;
            rx_data  = ~pkt[i];
        end
    endtask
    // Waits for the one answer of five bytes, stalling when slow
    task automatic recv_rsp(output logic [7:0] r [5], output bit ok);
        int k;
        bit hit;
        ok = 1'b1;
        for (int i = 0; i < 5; i++) begin
            k = 0;
            do begin
                @(negedge clk);
                tx_ready = !slow || (k % 3 == 2);
                hit = tx_valid && tx_ready;
                if (hit)
                    r[i] = tx_data;
                @(posedge clk);
                k++;
            end while (!hit && k < 3000);
            if (!hit)
                ok = 1'b0;
        end
        @(negedge clk);
        tx_ready = 1'b0;
    endtask
endmodule

//--- tb/diuch_top_bench.sv
// Self-checking bench for the update command handler
`timescale 1ns/100ps
module diuch_top_bench;
    import diuch_pkg::*;
    localparam logic [31:0] REV_T = 32'h1234_5678;
    localparam logic [31:0] ID_T  = 32'h5A5A_0001; // Arbitrary value
    logic        clk = 1'b0;
    logic        nrst, rx_valid, tx_valid, tx_ready, fl_write, fl_erase;
    logic        upper_alt, boot_swap, sys_reset, err_on;
    logic        fl_done = 1'b0;
    logic        fl_error = 1'b0;
    logic [7:0]  rx_data, tx_data, fl_wdata;
    logic [23:0] fl_addr, ptr;
    logic [15:0] image_crc_ref, img_crc;
    logic [7:0]  pkt [69];
    logic [7:0]  rsp [5];
    logic [23:0] wa [$];
    logic [7:0]  wd [$];
    int          miscompares, n_compared, n_erase, n_rst, fl_cnt;
    always #12.5 clk = ~clk;
    diuch_top #(.APP_REVISION(REV_T), .APP_ID(ID_T)) dut (
        .clk(clk), .nrst(nrst), .rx_valid(rx_valid), .rx_data(rx_data),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .fl_write(fl_write), .fl_erase(fl_erase), .fl_addr(fl_addr),
        .fl_wdata(fl_wdata), .fl_done(fl_done), .fl_error(fl_error),
        .upper_alt(upper_alt), .image_crc_ref(image_crc_ref),
        .boot_swap(boot_swap), .sys_reset(sys_reset));
    diuch_host_model host (
        .clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
    // ------------------------------------------------------------
    // Flash responder and event counters
    // ------------------------------------------------------------
    always @(negedge clk) begin
        fl_done  <= 1'b0;
        fl_error <= 1'b0;
        if (fl_cnt == 1) begin
            fl_done  <= !err_on;
            fl_error <= err_on;
        end
        if (fl_cnt > 0)
            fl_cnt <= fl_cnt - 1;
        if (fl_write === 1'b1) begin
            fl_cnt <= 2;
            wa.push_back(fl_addr);
            wd.push_back(fl_wdata);
        end
        if (fl_erase === 1'b1) begin
            fl_cnt <= 2;
            n_erase++;
        end
    end
    always @(negedge clk)
        if (sys_reset === 1'b1)
            n_rst++;
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] crc_b(logic [15:0] c, logic [7:0] b);
        c = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++)
            c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
        return c;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic [7:0] code, input logic [15:0] ctr,
                        input logic [7:0] seed, input bit bad);
        logic [15:0] c;
        bit          ok;
        c = CRC_SEED;
        pkt[0] = ctr[15:8];
        pkt[1] = ctr[7:0];
        pkt[2] = code;
        for (int i = 3; i < 67; i++)
            pkt[i] = seed + 8'(i);
        for (int i = 0; i < 67; i++)
            c = crc_b(c, pkt[i]);
        pkt[67] = c[7:0] ^ {7'h00, bad};
        pkt[68] = c[15:8];
        wa.delete();
        wd.delete();
        host.send_pkt(pkt);
        host.recv_rsp(rsp, ok);
        check(ok, 1'b1);
    endtask
    task automatic rsp_is(input logic [7:0] t, input logic [15:0] a,
                          input logic [15:0] b);
        check(rsp[0], t);
        check({rsp[1], rsp[2]}, a);
        check({rsp[3], rsp[4]}, b);
    endtask
    task automatic data_pkt(input logic [15:0] n, input bit alt);
        xfer(CMD_DATA, n, n[7:0], 1'b0);
        for (int i = 3; i < 67; i++)
            img_crc = crc_b(img_crc, pkt[i]);
        rsp_is(RSP_ACK_PKT, n, img_crc);
        check(wa.size(), 64);
        check(wa[0], ptr);
        check(wd[63], pkt[66]);
        ptr = ptr + PTR_STEP;
        if (ptr == PTR_BOOT_END)
            ptr = alt ? ALT_UPPER : ALT_LOWER;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_query;
        xfer(CMD_VERSION, 16'h0000, 8'h00, 1'b0);
        rsp_is(RSP_VERSION, REV_T[31:16], REV_T[15:0]);
        xfer(CMD_GET_APP, 16'h0000, 8'h00, 1'b0);
        rsp_is(RSP_APP, ID_T[31:16], ID_T[15:0]);
        xfer(CMD_GET_SWAP, 16'h0000, 8'h00, 1'b0);
        rsp_is(RSP_SWAP, 16'h0000, FILL16);
        $display("Test query done");
    endtask
    task automatic t_download(input bit alt);
        logic [15:0] n;
        upper_alt = alt;
        n_erase = 0;
        xfer(CMD_START, 16'h0000, 8'h00, 1'b0);
        check(n_erase, 1);
        rsp_is(RSP_READY, FILL16, FILL16);
        ptr = PTR_START;
        img_crc = CRC_SEED;
        for (n = 16'h0001; n <= 16'h0041; n++)
            data_pkt(n, alt);
        if (alt) begin
            xfer(CMD_DATA, n, 8'h10, 1'b1);
            rsp_is(RSP_NAK_CRC, n, FILL16);
            check(wa.size(), 0);
            xfer(8'h0C, n, 8'h10, 1'b0);
            rsp_is(RSP_NAK_PKT, n, FILL16);
            check(wa.size(), 0);
            err_on = 1'b1;
            xfer(CMD_DATA, n, n[7:0], 1'b0);
            err_on = 1'b0;
            rsp_is(RSP_NAK_PKT, n, FILL16);
            data_pkt(n, alt);
            n++;
        end
        n--;
        image_crc_ref = img_crc;
        xfer(CMD_DONE, n, 8'h00, 1'b0);
        rsp_is(RSP_ACK_PROG, n, img_crc);
        image_crc_ref = ~img_crc;
        xfer(CMD_DONE, n, 8'h00, 1'b0);
        rsp_is(RSP_NAK_PROG, n, img_crc);
        $display("Test download done");
    endtask
    task automatic t_resets;
        host.slow = 1'b1;
        n_rst = 0;
        xfer(CMD_RESET, 16'h0000, 8'h00, 1'b0);
        repeat (8) @(negedge clk);
        check(n_rst, 1);
        check(boot_swap, 1'b0);
        xfer(CMD_SWAP, 16'h0000, 8'h00, 1'b0);
        repeat (8) @(negedge clk);
        check(n_rst, 2);
        check(boot_swap, 1'b1);
        xfer(CMD_GET_SWAP, 16'h0000, 8'h00, 1'b0);
        rsp_is(RSP_SWAP, 16'h0001, FILL16);
        $display("Test resets done");
    endtask
    task automatic final_report;
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        nrst = 1'b0;
        err_on = 1'b0;
        upper_alt = 1'b0;
        image_crc_ref = 16'h0000;
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        t_query;
        t_download(1'b0);
        t_download(1'b1);
        t_resets;
        final_report;
    end
    initial begin
        #(25 * 90000);
        miscompares++;
        final_report;
    end
endmodule
bind diuch_top diuch_checker u_chk (
    .clk(clk), .nrst(nrst), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .fl_write(fl_write), .fl_erase(fl_erase),
    .fl_addr(fl_addr), .upper_alt(upper_alt), .boot_swap(boot_swap),
    .sys_reset(sys_reset));
